/* uec_pkg.sv */
// Shared constants and carrier types for the endpoint 0 control/status block
package uec_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets, low address byte)
  // ----------------------------------------------------------------
  localparam logic [7:0] UEC_CSR0_OFFSET = 8'h00;
  localparam logic [7:0] UEC_NAK_LIMIT_OFFSET = 8'h04;
  localparam logic [7:0] UEC_NAK_LIMIT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Peripheral-role field positions
  // ----------------------------------------------------------------
  localparam int UEC_P_DROP = 8;
  localparam int UEC_P_SERV_ABORT = 7;
  localparam int UEC_P_SERV_RX = 6;
  localparam int UEC_P_ISSUE_HALT = 5;
  localparam int UEC_P_ABORTED = 4;
  localparam int UEC_P_LAST_DATA = 3;
  localparam int UEC_P_STALL_SENT = 2;

  // ----------------------------------------------------------------
  // Host-role field positions
  // ----------------------------------------------------------------
  localparam int UEC_H_TOG_WREN = 10;
  localparam int UEC_H_TOGGLE = 9;
  localparam int UEC_H_DROP = 8;
  localparam int UEC_H_NAK_TIMEOUT = 7;
  localparam int UEC_H_STATUS = 6;
  localparam int UEC_H_REQ_IN = 5;
  localparam int UEC_H_ERROR = 4;
  localparam int UEC_H_SETUP = 3;
  localparam int UEC_H_STALL_RX = 2;

  // Shared by both layouts
  localparam int UEC_TX_RDY = 1;
  localparam int UEC_RX_RDY = 0;

  // ----------------------------------------------------------------
  // Counts and bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] UEC_RETRY_LIMIT = 2'h3;
  localparam logic [1:0] UEC_HTRANS_NONSEQ = 2'h2;

  // Events reported by the protocol engine, one-cycle pulses
  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic stall_tx;
    logic ctrl_end;
    logic stall_rx;
    logic nak;
    logic no_resp;
    logic toggle_flip;
  } uec_link_ev_t;

  // Controls presented to the protocol engine
  typedef struct packed {
    logic tx_ready;
    logic req_in;
    logic setup_sel;
    logic status_stage;
    logic issue_halt;
    logic last_data;
    logic ep_halted;
    logic toggle;
    logic flush;
    logic irq;
  } uec_link_ctl_t;

endpackage

/* uec_ep0_csr.sv */
// Endpoint 0 control/status register block with an AHB-Lite slave port
module uec_ep0_csr #(
  parameter int NAK_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic host_mode,
  input wire uec_pkg::uec_link_ev_t link_ev,
  output uec_pkg::uec_link_ctl_t link_ctl
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NAK_W < 1 || NAK_W > 16) begin : g_bad_nak_w
    $error("NAK_W must lie between 1 and 16");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic hreadyout_q;
  logic hresp_q;
  logic [31:0] hrdata_q;
  logic [7:0] addr_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [2:0] size_q;

  logic tx_rdy_q;
  logic rx_rdy_q;
  logic aborted_q;
  logic last_data_q;
  logic issue_halt_q;
  logic stall_sent_q;
  logic nak_to_q;
  logic status_q;
  logic req_q;
  logic error_q;
  logic setup_q;
  logic stall_rx_q;
  logic tog_wren_q;
  logic toggle_q;
  logic flush_q;
  logic irq_q;

  logic [NAK_W-1:0] nak_limit_q;
  logic [NAK_W-1:0] nak_cnt_q;
  logic [1:0] retry_q;

  logic addr_phase;
  logic wr_csr;
  logic wr_nak_limit;
  logic p_wr;
  logic h_wr;
  logic [15:0] wd;
  logic drop_ok;
  logic drop_tx;
  logic drop_rx;
  logic aborted_set;
  logic nak_hit;
  logic err_hit;
  logic new_xfer;
  logic any_resp;
  logic [15:0] csr_rd;
  logic [31:0] rd_val;

  localparam int UEC_TX_RDY_I = uec_pkg::UEC_TX_RDY;
  localparam int UEC_RX_RDY_I = uec_pkg::UEC_RX_RDY;

  // Bit pick from the write word, shared by both layouts
  function automatic logic wbit(input logic [15:0] w, input int pos);
    wbit = w[pos];
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign addr_phase = hsel && htrans == uec_pkg::UEC_HTRANS_NONSEQ && hready;

  // Writes are zero-wait; reads insert one wait state so that the read
  // word is taken from registered state and reflects a write just before.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
      addr_q <= 8'h00;
      size_q <= 3'h0;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else if (ce) begin
      hresp_q <= 1'b0;
      wr_pend_q <= 1'b0;
      if (rd_pend_q) begin
        hrdata_q <= rd_val;
        hreadyout_q <= 1'b1;
        rd_pend_q <= 1'b0;
      end
      if (addr_phase) begin
        addr_q <= haddr[7:0];
        size_q <= hsize;
        if (hwrite) begin
          wr_pend_q <= 1'b1;
        end else begin
          rd_pend_q <= 1'b1;
          hreadyout_q <= 1'b0;
        end
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Sub-word writes are ignored: a partial word would leave the
  // self-clearing command bits ambiguous.
  assign wr_csr = wr_pend_q && size_q == 3'h2 && addr_q == uec_pkg::UEC_CSR0_OFFSET;
  assign wr_nak_limit = wr_pend_q && size_q == 3'h2 && addr_q == uec_pkg::UEC_NAK_LIMIT_OFFSET;
  assign wd = hwdata[15:0];
  assign p_wr = wr_csr && !host_mode;
  assign h_wr = wr_csr && host_mode;

  // Flush only acts on a pending packet; transmit side goes first
  assign drop_ok = wr_csr && wbit(wd, uec_pkg::UEC_P_DROP) && (tx_rdy_q || rx_rdy_q);
  assign drop_tx = drop_ok && tx_rdy_q;
  assign drop_rx = drop_ok && !tx_rdy_q;

  assign aborted_set = !host_mode && link_ev.ctrl_end && !last_data_q;

  assign new_xfer = h_wr && (wbit(wd, UEC_TX_RDY_I) || wbit(wd, uec_pkg::UEC_H_REQ_IN));
  assign any_resp = link_ev.tx_done || link_ev.rx_done || link_ev.nak || link_ev.stall_rx;

  // Limit of zero leaves the timeout disabled
  assign nak_hit = host_mode && link_ev.nak && !nak_to_q && nak_limit_q != '0 &&
                   nak_cnt_q + NAK_W'(1) >= nak_limit_q;
  assign err_hit = host_mode && link_ev.no_resp && !any_resp &&
                   retry_q + 2'h1 == uec_pkg::UEC_RETRY_LIMIT;

  // ----------------------------------------------------------------
  // Shared packet-ready flags
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_rdy_q <= 1'b0;
      rx_rdy_q <= 1'b0;
    end else if (ce) begin
      if (link_ev.tx_done || drop_tx || aborted_set) begin
        tx_rdy_q <= 1'b0;
      end
      if (wr_csr && wbit(wd, UEC_TX_RDY_I) && !drop_ok) begin
        tx_rdy_q <= 1'b1;
      end
      if (drop_rx || (p_wr && wbit(wd, uec_pkg::UEC_P_SERV_RX)) ||
          (h_wr && !wbit(wd, UEC_RX_RDY_I))) begin
        rx_rdy_q <= 1'b0;
      end
      if (link_ev.rx_done) begin
        rx_rdy_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Peripheral-role flags
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aborted_q <= 1'b0;
      last_data_q <= 1'b0;
      issue_halt_q <= 1'b0;
      stall_sent_q <= 1'b0;
    end else if (ce) begin
      if (p_wr && wbit(wd, uec_pkg::UEC_P_SERV_ABORT)) begin
        aborted_q <= 1'b0;
      end
      if (aborted_set) begin
        aborted_q <= 1'b1;
      end
      if (link_ev.tx_done || link_ev.ctrl_end) begin
        last_data_q <= 1'b0;
      end
      if (p_wr && wbit(wd, uec_pkg::UEC_P_LAST_DATA)) begin
        last_data_q <= 1'b1;
      end
      if (!host_mode && link_ev.stall_tx) begin
        issue_halt_q <= 1'b0;
      end
      if (p_wr && wbit(wd, uec_pkg::UEC_P_ISSUE_HALT)) begin
        issue_halt_q <= 1'b1;
      end
      if (p_wr && !wbit(wd, uec_pkg::UEC_P_STALL_SENT)) begin
        stall_sent_q <= 1'b0;
      end
      if (!host_mode && link_ev.stall_tx) begin
        stall_sent_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Host-role flags
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nak_to_q <= 1'b0;
      status_q <= 1'b0;
      req_q <= 1'b0;
      error_q <= 1'b0;
      setup_q <= 1'b0;
      stall_rx_q <= 1'b0;
    end else if (ce) begin
      if (h_wr && !wbit(wd, uec_pkg::UEC_H_NAK_TIMEOUT)) begin
        nak_to_q <= 1'b0;
      end
      if (nak_hit) begin
        nak_to_q <= 1'b1;
      end
      if (link_ev.tx_done || link_ev.rx_done) begin
        status_q <= 1'b0;
      end
      if (new_xfer && wbit(wd, uec_pkg::UEC_H_STATUS)) begin
        status_q <= 1'b1;
      end
      if (h_wr && wbit(wd, uec_pkg::UEC_H_REQ_IN)) begin
        req_q <= 1'b1;
      end
      if (link_ev.rx_done) begin
        req_q <= 1'b0;
      end
      if (h_wr && !wbit(wd, uec_pkg::UEC_H_ERROR)) begin
        error_q <= 1'b0;
      end
      if (err_hit) begin
        error_q <= 1'b1;
      end
      if (link_ev.tx_done) begin
        setup_q <= 1'b0;
      end
      if (h_wr && wbit(wd, uec_pkg::UEC_H_SETUP) && wbit(wd, UEC_TX_RDY_I)) begin
        setup_q <= 1'b1;
      end
      if (h_wr && !wbit(wd, uec_pkg::UEC_H_STALL_RX)) begin
        stall_rx_q <= 1'b0;
      end
      if (host_mode && link_ev.stall_rx) begin
        stall_rx_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data toggle
  // ----------------------------------------------------------------
  // Status-stage forcing comes last so it overrides a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_wren_q <= 1'b0;
      toggle_q <= 1'b0;
    end else if (ce) begin
      if (link_ev.toggle_flip) begin
        toggle_q <= !toggle_q;
      end
      if (h_wr) begin
        if (tog_wren_q) begin
          toggle_q <= wbit(wd, uec_pkg::UEC_H_TOGGLE);
        end
        tog_wren_q <= wbit(wd, uec_pkg::UEC_H_TOG_WREN);
      end
      if (new_xfer && wbit(wd, uec_pkg::UEC_H_STATUS)) begin
        toggle_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // NAK and retry counters
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nak_limit_q <= NAK_W'(uec_pkg::UEC_NAK_LIMIT_RESET);
      nak_cnt_q <= '0;
      retry_q <= 2'h0;
    end else if (ce) begin
      if (wr_nak_limit) begin
        nak_limit_q <= hwdata[NAK_W-1:0];
      end
      if (new_xfer || link_ev.tx_done || link_ev.rx_done || link_ev.stall_rx || nak_hit) begin
        nak_cnt_q <= '0;
      end else if (host_mode && link_ev.nak && !nak_to_q) begin
        nak_cnt_q <= nak_cnt_q + NAK_W'(1);
      end
      if (new_xfer || any_resp || err_hit) begin
        retry_q <= 2'h0;
      end else if (host_mode && link_ev.no_resp) begin
        retry_q <= retry_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event pulses to the engine and the interrupt logic
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flush_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      flush_q <= drop_ok || aborted_set;
      irq_q <= link_ev.rx_done || (link_ev.tx_done && tx_rdy_q) ||
               aborted_set || err_hit;
    end
  end

  assign link_ctl.tx_ready = tx_rdy_q;
  assign link_ctl.req_in = req_q;
  assign link_ctl.setup_sel = setup_q;
  assign link_ctl.status_stage = status_q;
  assign link_ctl.issue_halt = issue_halt_q;
  assign link_ctl.last_data = last_data_q;
  assign link_ctl.ep_halted = nak_to_q;
  assign link_ctl.toggle = toggle_q;
  assign link_ctl.flush = flush_q;
  assign link_ctl.irq = irq_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Command bits (drop, serviced acks) always read back as zero
  always_comb begin
    csr_rd = 16'h0000;
    csr_rd[UEC_TX_RDY_I] = tx_rdy_q;
    csr_rd[UEC_RX_RDY_I] = rx_rdy_q;
    if (host_mode) begin
      csr_rd[uec_pkg::UEC_H_TOG_WREN] = tog_wren_q;
      csr_rd[uec_pkg::UEC_H_TOGGLE] = toggle_q;
      csr_rd[uec_pkg::UEC_H_NAK_TIMEOUT] = nak_to_q;
      csr_rd[uec_pkg::UEC_H_STATUS] = status_q;
      csr_rd[uec_pkg::UEC_H_REQ_IN] = req_q;
      csr_rd[uec_pkg::UEC_H_ERROR] = error_q;
      csr_rd[uec_pkg::UEC_H_SETUP] = setup_q;
      csr_rd[uec_pkg::UEC_H_STALL_RX] = stall_rx_q;
    end else begin
      csr_rd[uec_pkg::UEC_P_ISSUE_HALT] = issue_halt_q;
      csr_rd[uec_pkg::UEC_P_ABORTED] = aborted_q;
      csr_rd[uec_pkg::UEC_P_LAST_DATA] = last_data_q;
      csr_rd[uec_pkg::UEC_P_STALL_SENT] = stall_sent_q;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (addr_q == uec_pkg::UEC_CSR0_OFFSET) begin
      rd_val = {16'h0000, csr_rd};
    end else if (addr_q == uec_pkg::UEC_NAK_LIMIT_OFFSET) begin
      rd_val = 32'(nak_limit_q);
    end
  end

endmodule

/* uec_link_model.sv */
// Far-side partner model: answers endpoint 0 requests and injects bus events
module uec_link_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire uec_pkg::uec_link_ctl_t link_ctl,
  input wire uec_pkg::uec_link_ev_t inj,
  input wire logic auto_en,
  input wire logic [3:0] dly,
  output uec_pkg::uec_link_ev_t link_ev
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cnt_q;
  logic [1:0] hold_q;
  logic busy;

  assign busy = link_ctl.tx_ready | link_ctl.req_in | link_ctl.issue_halt;

  // Hold-off spans the cycle before the flags fall, so one request gets one answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      hold_q <= 2'h0;
      link_ev <= '0;
    end else begin
      link_ev <= inj;
      if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end else if (auto_en && busy) begin
        if (cnt_q == dly) begin
          cnt_q <= 4'h0;
          hold_q <= 2'h2;
          link_ev.tx_done <= link_ctl.tx_ready | inj.tx_done;
          link_ev.rx_done <= link_ctl.req_in | inj.rx_done;
          link_ev.stall_tx <= link_ctl.issue_halt | inj.stall_tx;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

/* uec_ep0_checker.sv */
// Concurrent checks on the endpoint 0 control/status block ports
module uec_ep0_checker #(
  parameter int NAK_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic host_mode,
  input wire uec_pkg::uec_link_ev_t link_ev,
  input wire uec_pkg::uec_link_ctl_t link_ctl
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence rd_taken;
    ce && hsel && hready && htrans == uec_pkg::UEC_HTRANS_NONSEQ && !hwrite;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait: assert property (rd_taken |=> rd_answer)
    else $error("read answer timing wrong");
  a_rx_irq: assert property (ce && link_ev.rx_done |=> link_ctl.irq)
    else $error("no irq after receive");
  a_req_cleared: assert property (ce && host_mode && link_ev.rx_done |=> !link_ctl.req_in)
    else $error("request not cleared");
  a_halt_clears: assert property (ce && !host_mode && link_ev.stall_tx |=> !link_ctl.issue_halt)
    else $error("halt request stuck");
  a_abort_flush: assert property (ce && !host_mode && link_ev.ctrl_end && !link_ctl.last_data
    |=> link_ctl.flush && link_ctl.irq) else $error("early end not flushed");
  a_tx_irq: assert property (ce && link_ev.tx_done && link_ctl.tx_ready |=> link_ctl.irq)
    else $error("no irq after transmit");
  a_status_data1: assert property ($rose(link_ctl.status_stage) |-> link_ctl.toggle)
    else $error("status stage not DATA1");
  a_setup_with_tx: assert property ($rose(link_ctl.setup_sel) |-> link_ctl.tx_ready)
    else $error("setup without transmit");
  a_nak_halt: assert property ($rose(link_ctl.ep_halted) |-> host_mode && $past(link_ev.nak))
    else $error("halt without nak");
  a_irq_cause: assert property (link_ctl.irq |->
    $past(link_ev.rx_done || link_ev.tx_done || link_ev.ctrl_end || link_ev.no_resp))
    else $error("irq without cause");
  a_flush_cause: assert property (link_ctl.flush |-> $past(hwdata[8] || link_ev.ctrl_end))
    else $error("flush without cause");
endmodule

bind uec_ep0_csr uec_ep0_checker #(.NAK_W(NAK_W)) uec_ep0_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .host_mode(host_mode), .link_ev(link_ev),
  .link_ctl(link_ctl)
);

/* uec_ep0_csr_tb_top.sv */
// Self-checking testbench for the endpoint 0 control/status block
module uec_ep0_csr_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] EV_RX = 8'h80;
  localparam logic [7:0] EV_CEND = 8'h10;
  localparam logic [7:0] EV_SRX = 8'h08;
  localparam logic [7:0] EV_NAK = 8'h04;
  localparam logic [7:0] EV_NR = 8'h02;
  localparam logic [7:0] EV_FLIP = 8'h01;

  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, host_mode, auto_en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] dly;
  uec_pkg::uec_link_ev_t link_ev, inj;
  uec_pkg::uec_link_ctl_t link_ctl;
  int mismatches, num_checks;

  assign hready = hreadyout;

  uec_ep0_csr #(.NAK_W(8)) uec_ep0_csr_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .host_mode(host_mode), .link_ev(link_ev),
    .link_ctl(link_ctl));
  uec_link_model uec_link_model_inst (.hclk(hclk), .hresetn(hresetn), .link_ctl(link_ctl),
    .inj(inj), .auto_en(auto_en), .dly(dly), .link_ev(link_ev));

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic chk(input logic [31:0] a, e, input string n);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    cmp(n, e, r);
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic ev(input logic [7:0] e);
    inj <= e;
    @(posedge hclk);
    inj <= 8'h00;
    repeat (3) @(posedge hclk);
  endtask
  // Bounded wait for the partner to answer a pending request
  task automatic wt();
    @(posedge hclk);
    for (int i = 0; i < 50 && (link_ctl.tx_ready | link_ctl.req_in | link_ctl.issue_halt); i++)
      @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(32'h0, 32'h0, "csr0 reset");
    chk(32'h4, 32'h0, "nak limit reset");
    wr(32'h8, 32'hFFFF);
    chk(32'h8, 32'h0, "unmapped");
    wr(32'h0, 32'hFFFF_FE00);
    chk(32'h0, 32'h0, "reserved");
  endtask
  task automatic t_rx();
    ev(EV_RX);
    chk(32'h0, 32'h1, "rx ready");
    wr(32'h0, 32'h40);
    chk(32'h0, 32'h0, "rx serviced");
  endtask
  task automatic t_tx();
    auto_en <= 1'b1;
    dly <= 4'h3;
    wr(32'h0, 32'h0A);
    wt();
    chk(32'h0, 32'h0, "tx done");
    dly <= 4'h0;
    wr(32'h0, 32'h20);
    wt();
    chk(32'h0, 32'h04, "stall sent");
    wr(32'h0, 32'h0);
    chk(32'h0, 32'h0, "stall cleared");
    auto_en <= 1'b0;
  endtask
  task automatic t_abort();
    wr(32'h0, 32'h02);
    ev(EV_CEND);
    chk(32'h0, 32'h10, "aborted");
    wr(32'h0, 32'h80);
    chk(32'h0, 32'h0, "abort serviced");
    wr(32'h0, 32'h02);
    wr(32'h0, 32'h100);
    chk(32'h0, 32'h0, "drop tx");
    ev(EV_RX);
    wr(32'h0, 32'h100);
    chk(32'h0, 32'h0, "drop rx");
  endtask
  task automatic t_host();
    host_mode <= 1'b1;
    @(posedge hclk);
    wr(32'h0, 32'h200);
    chk(32'h0, 32'h0, "toggle locked");
    wr(32'h0, 32'h400);
    chk(32'h0, 32'h400, "toggle armed");
    wr(32'h0, 32'h200);
    chk(32'h0, 32'h200, "toggle set");
    wr(32'h0, 32'h0);
    wr(32'h0, 32'h400);
    wr(32'h0, 32'h0);
    wr(32'h0, 32'h60);
    chk(32'h0, 32'h260, "status req");
    ev(EV_RX);
    chk(32'h0, 32'h201, "req done");
    wr(32'h0, 32'h0);
  endtask
  task automatic t_faults();
    ev(EV_NR);
    ev(EV_NR);
    chk(32'h0, 32'h200, "two no resp");
    ev(EV_NR);
    chk(32'h0, 32'h210, "error");
    wr(32'h0, 32'h0);
    wr(32'h4, 32'h2);
    chk(32'h4, 32'h2, "nak limit");
    ev(EV_NAK);
    chk(32'h0, 32'h200, "one nak");
    ev(EV_NAK);
    chk(32'h0, 32'h280, "nak timeout");
    wr(32'h0, 32'h0);
    ev(EV_SRX);
    chk(32'h0, 32'h204, "stall rx");
    wr(32'h0, 32'h0A);
    chk(32'h0, 32'h20A, "setup token");
    auto_en <= 1'b1;
    wt();
    chk(32'h0, 32'h200, "setup sent");
    ev(EV_FLIP);
    chk(32'h0, 32'h0, "toggle flipped");
  endtask
  // Clock enable low must hold every flag through a link event
  task automatic t_freeze();
    ce <= 1'b0;
    ev(EV_RX);
    ce <= 1'b1;
    chk(32'h0, 32'h0, "frozen rx");
    ev(EV_RX);
    chk(32'h0, 32'h1, "rx after freeze");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    {hresetn, hsel, hwrite, host_mode, auto_en} = '0;
    ce = 1'b1;
    {haddr, hwdata} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    dly = 4'h0;
    inj = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Only endpoint 0 is mapped, so no index write precedes any access
    t_reset();
    t_rx();
    t_tx();
    t_abort();
    t_host();
    t_faults();
    t_freeze();
    wrap_up();
  end
endmodule
